// ### core/pmfs_map.svh
// Timing constants and counter width for the power module fault sequencer.
// Assumes a 40 MHz clock; counts are derived from times in their own units.
`ifndef PMFS_MAP_SVH
`define PMFS_MAP_SVH
`define PMFS_CLK_HZ            40000000
`define PMFS_OC_PERSIST_MS     100
`define PMFS_OC_PERSIST_CYC    ((`PMFS_CLK_HZ / 1000) * `PMFS_OC_PERSIST_MS)
`define PMFS_LATCH_CLR_MS      1000
`define PMFS_LATCH_CLR_CYC     ((`PMFS_CLK_HZ / 1000) * `PMFS_LATCH_CLR_MS)
`define PMFS_UV_WAIT_S         4
`define PMFS_UV_WAIT_CYC       (`PMFS_CLK_HZ * `PMFS_UV_WAIT_S)
`define PMFS_UV_HOT_WAIT_S     13
`define PMFS_UV_HOT_WAIT_CYC   (`PMFS_CLK_HZ * `PMFS_UV_HOT_WAIT_S)
`define PMFS_RESTART_MS        100
`define PMFS_RESTART_CYC       ((`PMFS_CLK_HZ / 1000) * `PMFS_RESTART_MS)
`define PMFS_TURN_ON_WAIT_MS   10
`define PMFS_TURN_ON_WAIT_CYC  ((`PMFS_CLK_HZ / 1000) * `PMFS_TURN_ON_WAIT_MS)
`define PMFS_BUS_WAIT_MS       20
`define PMFS_BUS_WAIT_CYC      ((`PMFS_CLK_HZ / 1000) * `PMFS_BUS_WAIT_MS)
`define PMFS_CNT_W             32
`endif

// ### core/pmfs_pkg.sv
// Types shared by the power module fault sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pmfs_pkg;
  typedef enum logic [2:0] {
    PMFS_OFF      = 3'b000,
    PMFS_WAIT_ON  = 3'b001,
    PMFS_RUN      = 3'b010,
    PMFS_RESTART  = 3'b011,
    PMFS_LATCHED  = 3'b100,
    PMFS_UV_WAIT  = 3'b101
  } pmfs_state_e;

  typedef struct packed {
    logic oc_limit;
    logic oc_surge;
    logic oc_sag;
    logic ov;
    logic ot;
    logic vin_uv;
    logic vin_ov;
  } pmfs_sense_s;

  typedef struct packed {
    logic oc_trip;
    logic ov_trip;
    logic ot_trip;
    logic lockout;
  } pmfs_cause_s;
endpackage : pmfs_pkg
`default_nettype wire

// ### core/pmfs_timer.sv
// Down-counting delay timer: load starts it, done pulses level high at zero.
// Assumes load_in and value_in are synchronous to clock_in.
`default_nettype none
module pmfs_timer #(
  parameter int W = 32
) (
  input  wire logic         clock_in,
  input  wire logic         rst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  output logic              busy_out,
  output logic              done_out
);
  logic [W-1:0] cnt_q;
  logic         busy_q;
  logic         done_q;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (load_in) begin
      cnt_q  <= value_in;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - W'(1);
      busy_q <= (cnt_q > W'(1));
      done_q <= (cnt_q <= W'(1));
    end else begin
      done_q <= 1'b0;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
endmodule : pmfs_timer
`default_nettype wire

// ### core/pmfs_persist.sv
// Counts consecutive cycles a level stays high; flags when the count passes a limit.
// Assumes level_in is synchronous to clock_in.
`default_nettype none
module pmfs_persist #(
  parameter int W = 32
) (
  input  wire logic         clock_in,
  input  wire logic         rst_n_in,
  input  wire logic         level_in,
  input  wire logic [W-1:0] limit_in,
  output logic              over_out
);
  logic [W-1:0] cnt_q;
  logic         over_q;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !level_in) begin
      cnt_q  <= '0;
      over_q <= 1'b0;
    end else begin
      if (cnt_q != limit_in) begin
        cnt_q <= cnt_q + W'(1);
      end
      over_q <= (cnt_q == limit_in);
    end
  end

  assign over_out = over_q;
endmodule : pmfs_persist
`default_nettype wire

// ### core/pmfs_sequencer.sv
// Protection and enable sequencer of an isolated DC-DC power module.
// Assumes all sense inputs are clean comparator levels synchronous to clock_in.
`include "pmfs_map.svh"
`default_nettype none
// Contract
// R1: Overcurrent held longer than 100 ms shuts output down; limiting continues before.
// R2: Current above surge threshold shuts output down at once.
// R3: Output sagging over 4 V below setpoint from overcurrent shuts down.
// R4: One strap policy, restart or latch, governs overcurrent and overvoltage together.
// R5: Restart policy retries after shutdown until the fault clears.
// R6: Latch policy stays off until power cycles or enable held off 1 s.
// R7: After latch reset, a standing overload trips and latches again.
// R8: Positive polarity runs on enable high, stops on low.
// R9: Negative polarity, the default, stops on enable high, runs on low.
// R10: Overvoltage shuts down and, under latch policy, latches; cleared by power cycle or 1 s toggle.
// R11: Standing overvoltage trips again on every restart without limit.
// R12: Overtemperature shuts down; restarts after cooling about 25 degrees.
// R13: Warning variants drive a separate overtemperature warning output.
// R14: Input outside lockout window disables operation; resumes when inside.
// R15: Restart after input undervoltage waits 4 s, or 13 s when hot.
// R16: Host enables paralleled modules one by one, spaced by delay plus rise.
// R17: Droop option lengthens turn-on wait when output bus already has voltage.
// R18: Host keeps load under half rating until all paralleled modules start.
// R19: Latch clears only after enable stays off for the full second.
module pmfs_sequencer
  import pmfs_pkg::*;
#(
  parameter int          CNT_W        = `PMFS_CNT_W,
  parameter int unsigned OC_PERSIST   = `PMFS_OC_PERSIST_CYC,
  parameter int unsigned LATCH_CLR    = `PMFS_LATCH_CLR_CYC,
  parameter int unsigned UV_WAIT      = `PMFS_UV_WAIT_CYC,
  parameter int unsigned UV_HOT_WAIT  = `PMFS_UV_HOT_WAIT_CYC,
  parameter int unsigned RESTART_WAIT = `PMFS_RESTART_CYC,
  parameter int unsigned TURN_ON_WAIT = `PMFS_TURN_ON_WAIT_CYC,
  parameter int unsigned BUS_WAIT     = `PMFS_BUS_WAIT_CYC
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        power_good_in_in,
  input  wire logic        remote_enable_in,
  input  wire logic        neg_polarity_in,
  input  wire logic        latch_policy_in,
  input  wire logic        warn_option_in,
  input  wire logic        droop_option_in,
  input  wire logic        bus_voltage_in,
  input  wire logic        hot_in,
  input  wire logic        ot_warn_level_in,
  input  wire logic        ot_cool_in,
  input  wire pmfs_sense_s sense_in,
  output logic             output_enable_out,
  output logic             current_limit_out,
  output logic             ot_warning_out,
  output logic             latched_out,
  output pmfs_cause_s      cause_out,
  output pmfs_state_e      state_out
);
  function automatic logic [CNT_W-1:0] cnt(input int unsigned v);
    cnt = CNT_W'(v);
  endfunction : cnt

  pmfs_state_e state_q;
  pmfs_state_e state_d;
  pmfs_cause_s cause_q;
  pmfs_cause_s cause_d;
  logic        latch_pol_q;
  logic        ot_hold_q;
  logic        uv_seen_q;
  logic        warn_q;
  logic        oc_long;
  logic        off_long;
  logic        tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic        tmr_done;

  // Latch the policy strap once after reset release, never under reset.
  logic        strap_taken_q;

  wire logic run_cmd   = neg_polarity_in ? !remote_enable_in  // R9
                                         : remote_enable_in;  // R8
  wire logic lockout   = sense_in.vin_uv || sense_in.vin_ov;  // R14
  wire logic oc_now    = sense_in.oc_surge   // R2
                      || sense_in.oc_sag     // R3
                      || oc_long;            // R1
  wire logic ov_now    = sense_in.ov;
  wire logic ot_now    = sense_in.ot;
  wire logic prot_trip = oc_now || ov_now;
  wire logic ot_block  = ot_now || ot_hold_q;  // R12
  wire logic can_run   = power_good_in_in && run_cmd && !lockout && !ot_block;
  wire logic uv_delay  = hot_in ? 1'b1 : 1'b0;
  wire logic [CNT_W-1:0] uv_value = uv_delay ? cnt(UV_HOT_WAIT) : cnt(UV_WAIT);  // R15
  wire logic [CNT_W-1:0] on_value = (droop_option_in && bus_voltage_in)
                                  ? cnt(BUS_WAIT)        // R17
                                  : cnt(TURN_ON_WAIT);

  pmfs_persist #(
    .W (CNT_W)
  ) u_oc_persist (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .level_in (sense_in.oc_limit),
    .limit_in (cnt(OC_PERSIST)),
    .over_out (oc_long)
  );

  // Enable must sit in its off state for a full second before a latch clears.
  pmfs_persist #(
    .W (CNT_W)
  ) u_off_persist (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .level_in (!run_cmd),
    .limit_in (cnt(LATCH_CLR - 1)),
    .over_out (off_long)
  );

  pmfs_timer #(
    .W (CNT_W)
  ) u_timer (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .load_in  (tmr_load),
    .value_in (tmr_value),
    .busy_out (),
    .done_out (tmr_done)
  );

  always_comb begin
    state_d   = state_q;
    cause_d   = cause_q;
    tmr_load  = 1'b0;
    tmr_value = on_value;
    case (state_q)
      PMFS_OFF: begin
        if (can_run) begin
          state_d  = uv_seen_q ? PMFS_UV_WAIT : PMFS_WAIT_ON;
          tmr_load = 1'b1;
          tmr_value = uv_seen_q ? uv_value : on_value;
        end
      end
      PMFS_UV_WAIT: begin
        if (!can_run) begin
          state_d = PMFS_OFF;
        end else if (tmr_done) begin
          state_d  = PMFS_WAIT_ON;
          tmr_load = 1'b1;
        end
      end
      PMFS_WAIT_ON: begin
        if (!can_run) begin
          state_d = PMFS_OFF;
        end else if (tmr_done) begin
          state_d = PMFS_RUN;
        end
      end
      PMFS_RUN: begin
        cause_d = '0;
        if (prot_trip) begin
          cause_d.oc_trip = oc_now;
          cause_d.ov_trip = ov_now;
          if (latch_pol_q) begin  // R4 R10
            state_d = PMFS_LATCHED;  // R6 R7
          end else begin
            state_d  = PMFS_RESTART;  // R5 R11
            tmr_load = 1'b1;
            tmr_value = cnt(RESTART_WAIT);
          end
        end else if (ot_now) begin
          cause_d.ot_trip = 1'b1;
          state_d = PMFS_OFF;  // R12
        end else if (!can_run) begin
          cause_d.lockout = lockout;
          state_d = PMFS_OFF;  // R14
        end
      end
      PMFS_RESTART: begin
        if (tmr_done) begin
          state_d = PMFS_OFF;  // R5
        end
      end
      PMFS_LATCHED: begin
        if (off_long) begin
          state_d = PMFS_OFF;  // R19
        end
      end
      default: begin
        state_d = PMFS_OFF;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q <= PMFS_OFF;
      cause_q <= '0;
    end else if (!power_good_in_in) begin
      state_q <= PMFS_OFF;  // R6
      cause_q <= cause_q;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      strap_taken_q <= 1'b0;
      latch_pol_q   <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      latch_pol_q   <= latch_policy_in;  // R4
    end
  end

  // Overtemperature holds the module off until the cool-down comparator releases.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ot_hold_q <= 1'b0;
    end else if (ot_now) begin
      ot_hold_q <= 1'b1;
    end else if (ot_cool_in) begin
      ot_hold_q <= 1'b0;  // R12
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      uv_seen_q <= 1'b0;
    end else if (sense_in.vin_uv) begin
      uv_seen_q <= 1'b1;  // R15
    end else if (state_q == PMFS_UV_WAIT && tmr_done) begin
      uv_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      warn_q <= 1'b0;
    end else begin
      warn_q <= warn_option_in && ot_warn_level_in;  // R13
    end
  end

  assign output_enable_out = (state_q == PMFS_RUN);
  assign current_limit_out = (state_q == PMFS_RUN) && sense_in.oc_limit;  // R1
  assign ot_warning_out    = warn_q;
  assign latched_out       = (state_q == PMFS_LATCHED);
  assign cause_out         = cause_q;
  assign state_out         = state_q;
endmodule : pmfs_sequencer
`default_nettype wire

// ### testbench/pmfs_host.sv
// Host model that drives the remote on/off pin of one module.
// Assumes the bench sets run_req_in just after a falling edge.
`default_nettype none
module pmfs_host (
  input  wire logic clock_in,
  input  wire logic neg_polarity_in,
  input  wire logic run_req_in,
  output var  logic remote_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // One module only, so enables are never bunched and load stays with the bench.
  always_comb remote_enable_out = run_req_in ^ neg_polarity_in;
endmodule : pmfs_host
`default_nettype wire

// ### testbench/pmfs_monitor.sv
// Port checker for the fault sequencer, attached by bind.
// Assumes straps only change while reset is held.
`default_nettype none
module pmfs_monitor
  import pmfs_pkg::*;
#(
  parameter int unsigned OC_PERSIST = 20,
  parameter int unsigned LATCH_CLR  = 40
) (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        power_good_in_in,
  input wire logic        remote_enable_in,
  input wire logic        neg_polarity_in,
  input wire logic        latch_policy_in,
  input wire logic        warn_option_in,
  input wire logic        ot_warn_level_in,
  input wire pmfs_sense_s sense_in,
  input wire logic        output_enable_out,
  input wire logic        current_limit_out,
  input wire logic        ot_warning_out,
  input wire logic        latched_out,
  input wire pmfs_cause_s cause_out,
  input wire pmfs_state_e state_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic        run, pin_on, go;
  logic [31:0] oc_q, off_q;
  assign run    = state_out == PMFS_RUN;
  assign pin_on = remote_enable_in ^ neg_polarity_in;
  assign go     = run && pin_on && power_good_in_in && !sense_in.ot
                  && !sense_in.vin_uv && !sense_in.vin_ov;
  always_ff @(posedge clock_in) begin
    oc_q  <= (rst_n_in && run && sense_in.oc_limit) ? oc_q + 32'h1 : 32'h0;
    off_q <= (rst_n_in && !pin_on) ? off_q + 32'h1 : 32'h0;
  end
  sequence s_stop;
    !output_enable_out && !run;
  endsequence
  surge_trip_a: assert property (go && sense_in.oc_surge |=> s_stop ##0
    latched_out == latch_policy_in) else $error("surge did not stop output");
  sag_trip_a: assert property (go && sense_in.oc_sag |=> s_stop ##0 cause_out.oc_trip)
    else $error("sag did not stop output");
  ov_trip_a: assert property (go && sense_in.ov |=> s_stop ##0 cause_out.ov_trip)
    else $error("overvoltage did not stop output");
  ot_trip_a: assert property (run && power_good_in_in && sense_in.ot |=> s_stop)
    else $error("overtemperature did not stop output");
  lockout_stop_a: assert property (run && (sense_in.vin_uv || sense_in.vin_ov) |=> s_stop)
    else $error("lockout did not stop output");
  enable_off_a: assert property (run && !pin_on |-> ##[1:2] !output_enable_out)
    else $error("pin off did not stop output");
  limit_flag_a: assert property (run && sense_in.oc_limit |-> current_limit_out)
    else $error("current limit flag missing");
  oc_persist_a: assert property (oc_q <= OC_PERSIST + 32'd3)
    else $error("overcurrent ran too long");
  power_loss_a: assert property (!power_good_in_in |=> !latched_out && !output_enable_out)
    else $error("power loss did not clear");
  latch_hold_a: assert property (latched_out && power_good_in_in
    && off_q + 32'd2 < LATCH_CLR |=> latched_out) else $error("latch cleared early");
  latch_clear_a: assert property (off_q > LATCH_CLR + 32'd4 |-> !latched_out)
    else $error("latch not cleared");
  warn_out_a: assert property (ot_warning_out == $past(warn_option_in && ot_warn_level_in))
    else $error("warning output wrong");
endmodule : pmfs_monitor
bind pmfs_sequencer pmfs_monitor #(
  .OC_PERSIST (OC_PERSIST),
  .LATCH_CLR  (LATCH_CLR)
) u_mon (
  .clock_in          (clock_in),
  .rst_n_in          (rst_n_in),
  .power_good_in_in  (power_good_in_in),
  .remote_enable_in  (remote_enable_in),
  .neg_polarity_in   (neg_polarity_in),
  .latch_policy_in   (latch_policy_in),
  .warn_option_in    (warn_option_in),
  .ot_warn_level_in  (ot_warn_level_in),
  .sense_in          (sense_in),
  .output_enable_out (output_enable_out),
  .current_limit_out (current_limit_out),
  .ot_warning_out    (ot_warning_out),
  .latched_out       (latched_out),
  .cause_out         (cause_out),
  .state_out         (state_out)
);
`default_nettype wire

// ### testbench/pmfs_sequencer_tb.sv
// Self-checking bench for the fault sequencer with shortened counts.
// Assumes the host model and the bound checker are compiled alongside.
`default_nettype none
module pmfs_sequencer_tb
  import pmfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OCP = 20, LCLR = 40, UVW = 30, UVH = 60, RSW = 10, TOW = 5, BSW = 12;
  logic clock_in = 0, rst_n_in = 0, pg = 1, neg = 1, lpol = 0, warn = 0, droop = 0;
  logic busv = 0, hot = 0, wl = 0, cool = 0, req = 0, ren, oe, cl, otw, lat;
  pmfs_sense_s sense = '0;
  pmfs_cause_s cause;
  pmfs_state_e st;
  int          mismatches = 0, checked = 0, n, d1;
  logic [31:0] rs = 32'h7302f7f1;
  always #12.5 clock_in = ~clock_in;
  pmfs_host u_host (.clock_in(clock_in), .neg_polarity_in(neg), .run_req_in(req),
    .remote_enable_out(ren));
  pmfs_sequencer #(.OC_PERSIST(OCP), .LATCH_CLR(LCLR), .UV_WAIT(UVW), .UV_HOT_WAIT(UVH),
    .RESTART_WAIT(RSW), .TURN_ON_WAIT(TOW), .BUS_WAIT(BSW)) u_dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .power_good_in_in(pg), .remote_enable_in(ren),
    .neg_polarity_in(neg), .latch_policy_in(lpol), .warn_option_in(warn),
    .droop_option_in(droop), .bus_voltage_in(busv), .hot_in(hot), .ot_warn_level_in(wl),
    .ot_cool_in(cool), .sense_in(sense), .output_enable_out(oe), .current_limit_out(cl),
    .ot_warning_out(otw), .latched_out(lat), .cause_out(cause), .state_out(st));
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic int exp_uv(int k);
    return (k == 0) ? 0 : (k == 1) ? UVW : UVH;
  endfunction : exp_uv
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(int k);
    repeat (k) @(negedge clock_in);
  endtask : cyc
  task automatic wait_st(pmfs_state_e s, output int k);
    k = 0;
    while (st !== s && k < 2000) begin
      @(negedge clock_in);
      k++;
    end
    if (k >= 2000) chk("wait state", st, s);
  endtask : wait_st
  task automatic do_reset(logic p);
    rst_n_in = 0;
    {lpol, sense, req, warn, wl, pg} = {p, 7'h00, 4'h1};
    cyc(2);
    rst_n_in = 1;
    cyc(2);
  endtask : do_reset
  task automatic start(output int k);
    req = 1;
    wait_st(PMFS_RUN, k);
    chk("run", oe, 1);
  endtask : start
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #(25ns * 30000);
    mismatches++;
    print_verdict();
  end
  initial begin
    for (int p = 0; p < 2; p++) begin
      neg = p[0];
      do_reset(0);
      start(d1);
      {droop, busv, req} = 3'b110;
      cyc(2);
      chk("pin off", oe, 0);
      start(n);
      chk("droop wait", n - d1, BSW - TOW);
      {droop, busv} = 2'b00;
    end
    sense.oc_limit = 1;
    cyc(OCP - 3);
    chk("limit", cl, 1);
    chk("still on", oe, 1);
    sense.oc_limit = 0;
    cyc(1);
    sense.oc_limit = 1;
    cyc(OCP);
    chk("restarted count", oe, 1);
    cyc(5);
    chk("oc cause", {oe, cause}, 5'h08);
    for (int p = 0; p < 2; p++) for (int f = 0; f < 3; f++) begin
      do_reset(p[0]);
      start(n);
      sense = pmfs_sense_s'(7'h20 >> f);
      cyc(1);
      chk("trip", st, p ? PMFS_LATCHED : PMFS_RESTART);
      chk("cause", cause, (f == 2) ? 32'h4 : 32'h8);
      if (p) begin
        req = 0;
        cyc(LCLR / 2);
        req = 1;
        cyc(TOW + 4);
        chk("short toggle", lat, 1);
        req = 0;
        cyc(LCLR + 3);
        req = 1;
      end
      wait_st(PMFS_RUN, n);
      cyc(1);
      chk("again", st, p ? PMFS_LATCHED : PMFS_RESTART);
      pg = 0;
      cyc(1);
      chk("power cycle", lat, 0);
    end
    do_reset(0);
    start(n);
    sense = 7'h04;
    cyc(1);
    chk("ot cause", {oe, cause}, 5'h02);
    sense = '0;
    cyc(10);
    chk("ot hold", oe, 0);
    cool = 1;
    start(n);
    cool = 0;
    for (int k = 0; k < 3; k++) begin
      hot = (k == 2);
      sense = (k == 0) ? 7'h01 : 7'h02;
      cyc(1);
      chk("lock", {oe, cause}, 5'h01);
      sense = '0;
      wait_st(PMFS_RUN, n);
      chk("resume", n >= exp_uv(k) && n <= exp_uv(k) + TOW + 6, 1);
    end
    for (int i = 0; i < 200; i++) begin
      rs = xs(rs);
      {warn, wl} = rs[1:0];
      cyc(1);
      chk("ot warn", otw, warn & wl);
    end
    print_verdict();
  end
endmodule : pmfs_sequencer_tb
`default_nettype wire
